// File: hw/clock_generator_monitor.sv
// clock generator and clock activity monitor
// clock-like inputs are sampled levels synchronous to clk_sys, stop_mode comes from the core
`timescale 1ns/100ps
module clock_generator_monitor
	import clkgen_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic              internal_base_clock,
	input  wire logic              internal_clock,
	input  wire logic              external_clock,
	input  wire logic              external_reference,
	input  wire logic              internal_reference,
	input  wire logic              filter_stable_signal,
	input  wire logic              filter_sample,
	input  wire logic              internal_gen_on,
	input  wire logic              external_gen_on,
	input  wire logic              crystal_select,
	input  wire logic              run_in_stop,
	input  wire logic              stop_mode,
	input  wire logic              bus_select_ext,
	input  wire logic [MULT_W-1:0] freq_multiplier,
	output logic                   osc_out_clock,
	output logic                   gen_out_clock,
	output logic                   bus_clock,
	output logic                   timebase_clock,
	output logic                   internal_inactive_flag,
	output logic                   internal_stable_flag,
	output logic                   external_inactive_flag,
	output logic                   external_stable_flag,
	output logic [MULT_W-1:0]      active_multiplier,
	output logic                   crystal_range
);
	logic       int_run, ext_run, src_clk, internal_base_clock_q, external_clock_q, external_reference_q, internal_reference_q;
	logic       internal_base_clock_fall, external_clock_fall, external_reference_rise, internal_reference_rise;
	logic       seen_i_q, seen_e_q;
	logic [1:0] miss_i_q, miss_e_q, good_q;
	logic       div_q;
	logic [STAB_W-1:0] stab_q;
	logic [STAB_W-1:0] stab_target;

	// halting clocks in stop unless told to keep running
	assign int_run = internal_gen_on & (~stop_mode | run_in_stop);
	assign ext_run = external_gen_on & (~stop_mode | run_in_stop);
	assign src_clk = bus_select_ext ? (external_clock & ext_run) : (internal_clock & int_run);
	assign internal_base_clock_fall = internal_base_clock_q & ~internal_base_clock;
	assign external_clock_fall  = external_clock_q & ~external_clock;
	assign external_reference_rise  = ~external_reference_q & external_reference;
	assign internal_reference_rise  = ~internal_reference_q & internal_reference;
	assign stab_target = crystal_select ? STAB_W'(XTAL_STAB_CYCLES - 1)
	                                    : STAB_W'(EXT_STAB_CYCLES - 1);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			internal_base_clock_q <= 1'b0;
			external_clock_q  <= 1'b0;
			external_reference_q  <= 1'b0;
			internal_reference_q  <= 1'b0;
		end else begin
			internal_base_clock_q <= internal_base_clock;
			external_clock_q  <= external_clock;
			external_reference_q  <= external_reference;
			internal_reference_q  <= internal_reference;
		end
	end

	// osc follows the selected source; gen halves it and bus halves gen
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			div_q          <= 1'b0;
			gen_out_clock  <= 1'b0;
			osc_out_clock  <= 1'b0;
			bus_clock      <= 1'b0;
		end else begin
			osc_out_clock <= src_clk;
			// each source rise flips gen; every second one flips bus
			if (src_clk & ~osc_out_clock) begin
				div_q         <= ~div_q;
				gen_out_clock <= ~gen_out_clock;
				if (div_q)
					bus_clock <= ~bus_clock;
			end
			// dividers restart from a known phase once clocks come back after both int_run and ext_run drop
			if (!int_run && !ext_run) begin
				div_q         <= 1'b0;
				gen_out_clock <= 1'b0;
				bus_clock     <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			timebase_clock <= 1'b0;
		else if (external_stable_flag)
			timebase_clock <= external_clock & ext_run;
		else
			timebase_clock <= internal_clock & int_run;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			active_multiplier <= '0;
			crystal_range     <= 1'b0;
		end else begin
			active_multiplier <= freq_multiplier;
			crystal_range     <= crystal_select;
		end
	end

	// internal activity: count reference low phases lacking a base edge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			seen_i_q               <= 1'b0;
			miss_i_q               <= 2'h0;
			internal_inactive_flag <= 1'b0;
		end else begin
			if (!external_reference && internal_base_clock_fall) begin
				seen_i_q               <= 1'b1;
				miss_i_q               <= 2'h0;
				internal_inactive_flag <= 1'b0;
			end else if (external_reference_rise) begin
				seen_i_q <= 1'b0;
				if (!seen_i_q && miss_i_q != MISS_LIMIT)
					miss_i_q <= miss_i_q + 2'h1;
				if (!seen_i_q && miss_i_q == MISS_LIMIT - 2'h1)
					internal_inactive_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			good_q               <= 2'h0;
			internal_stable_flag <= 1'b0;
		end else if (!filter_stable_signal || !int_run || internal_inactive_flag) begin
			good_q               <= 2'h0;
			internal_stable_flag <= 1'b0;
		end else if (filter_sample) begin
			if (good_q != GOOD_LIMIT)
				good_q <= good_q + 2'h1;
			if (good_q == GOOD_LIMIT - 2'h1)
				internal_stable_flag <= 1'b1;
		end
	end

	// external activity mirrors the internal detector with roles swapped
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			seen_e_q               <= 1'b0;
			miss_e_q               <= 2'h0;
			external_inactive_flag <= 1'b0;
		end else begin
			if (!internal_reference && external_clock_fall) begin
				seen_e_q               <= 1'b1;
				miss_e_q               <= 2'h0;
				external_inactive_flag <= 1'b0;
			end else if (internal_reference_rise) begin
				seen_e_q <= 1'b0;
				if (!seen_e_q && miss_e_q != MISS_LIMIT)
					miss_e_q <= miss_e_q + 2'h1;
				if (!seen_e_q && miss_e_q == MISS_LIMIT - 2'h1)
					external_inactive_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stab_q               <= '0;
			external_stable_flag <= 1'b0;
		end else if (!ext_run || external_inactive_flag) begin
			stab_q               <= '0;
			external_stable_flag <= 1'b0;
		end else if (external_clock_fall && !external_stable_flag) begin
			stab_q <= stab_q + STAB_W'(1);
			if (stab_q == stab_target)
				external_stable_flag <= 1'b1;
		end
	end

	property p_int_clear;
		@(posedge clk_sys) disable iff (!nrst)
		(!external_reference && internal_base_clock_fall) |=> !internal_inactive_flag;
	endproperty
	AST_INT_CLEAR: assert property (p_int_clear) else $error("internal inactive not cleared");
	AST_EXT_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!internal_reference && external_clock_fall) |=> !external_inactive_flag)
		else $error("external inactive not cleared");
	AST_INT_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(internal_inactive_flag) |->
		$past(external_reference_rise) && !$past(seen_i_q) && $past(miss_i_q) == 2'h1)
		else $error("internal inactive set without missed phase");
	AST_EXT_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(external_inactive_flag) |-> $past(internal_reference_rise) && !$past(seen_e_q))
		else $error("external inactive set without missed phase");
	AST_ISTB_CLR: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!filter_stable_signal || !int_run || internal_inactive_flag) |=> !internal_stable_flag)
		else $error("internal stable not cleared");
	AST_ISTB_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(internal_stable_flag) |-> $past(good_q) == 2'h1 && $past(filter_sample))
		else $error("internal stable set early");
	AST_ESTB_CLR: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!ext_run || external_inactive_flag) |=> !external_stable_flag)
		else $error("external stable not cleared");
	AST_ESTB_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(external_stable_flag) |-> $past(stab_q) == $past(stab_target))
		else $error("external stable set at wrong count");
	AST_STOP_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
		(stop_mode && !run_in_stop) |=>
		!gen_out_clock && !timebase_clock && !osc_out_clock && !bus_clock)
		else $error("clock running in stop");
	sequence s_osc_up;
		$rose(osc_out_clock);
	endsequence
	property p_gen_half;
		@(posedge clk_sys) disable iff (!nrst)
		s_osc_up |-> $changed(gen_out_clock);
	endproperty
	AST_GEN_HALF: assert property (p_gen_half) else $error("gen clock not half of osc");
endmodule

// File: hw/clkgen_pkg.sv
// constants for the clock generator and clock monitor
// assumes a single 125 MHz system clock; all clock inputs arrive synchronous to it
package clkgen_pkg;
	localparam int          BASE_FREQ_HZ     = 307200;
	localparam int          BUS_STEP_HZ      = 76800;
	localparam int          MULT_W           = 7;
	localparam int          XTAL_STAB_CYCLES = 4096;
	localparam int          EXT_STAB_CYCLES  = 16;
	localparam int          STAB_W           = 13;
	localparam int          XTAL_MIN_HZ      = 30000;
	localparam int          EXT_MAX_HZ       = 32000000;
	localparam logic [1:0]  MISS_LIMIT       = 2'h2;
	localparam logic [1:0]  GOOD_LIMIT       = 2'h2;
	localparam logic [1:0]  BUS_DIV_OSC      = 2'h3;
endpackage

// File: sim/clk_src.sv
// oscillator stand-in: a level clock stepped by clk_sys
// assumes run comes from the bench; holds low while stopped
`timescale 1ns/100ps
module clk_src #(
	parameter int HALF = 2
) (
	input  wire logic clk_sys,
	input  wire logic nrst,
	input  wire logic run,
	output logic      clk_o
);
	int cnt;
	// a halted source reads low, never its last level
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
			clk_o <= 1'b0;
		end else if (!run) begin
			cnt <= 0;
			clk_o <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			clk_o <= ~clk_o;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// File: sim/clock_generator_monitor_tb.sv
// bench for the clock generator and activity monitor
// assumes clk_src stand-ins; flags lag their cause by one edge
`timescale 1ns/100ps
module clock_generator_monitor_tb;
	import clkgen_pkg::*;
	logic clk_sys = 1'b0, nrst = 1'b0, base_run = 1'b0, int_run = 1'b0, ext_run = 1'b0;
	logic internal_base_clock, internal_clock, external_clock, e;
	logic external_reference = 1'b0, internal_reference = 1'b0;
	logic filter_stable_signal = 1'b0, filter_sample = 1'b0, stop_mode = 1'b0;
	logic internal_gen_on = 1'b0, external_gen_on = 1'b0, bus_select_ext = 1'b0;
	logic crystal_select = 1'b0, run_in_stop = 1'b0;
	logic [MULT_W-1:0] freq_multiplier = 7'h00, active_multiplier;
	logic osc_out_clock, gen_out_clock, bus_clock, timebase_clock, crystal_range;
	logic internal_inactive_flag, internal_stable_flag;
	logic external_inactive_flag, external_stable_flag;
	int n_mismatch = 0, n_compared = 0, k;
	int r_osc, r_gen, r_bus;
	// {crystal_select, multiplier} beside {crystal_range, active multiplier}
	logic [15:0] rows [3] = '{16'h0000, 16'h7F7F, 16'h8585};

	always #4 clk_sys = ~clk_sys;
	clk_src #(.HALF(1)) base_u (.clk_sys, .nrst, .run(base_run), .clk_o(internal_base_clock));
	clk_src #(.HALF(1)) int_u (.clk_sys, .nrst, .run(int_run), .clk_o(internal_clock));
	clk_src #(.HALF(2)) ext_u (.clk_sys, .nrst, .run(ext_run), .clk_o(external_clock));
	clock_generator_monitor dut_u (
		.clk_sys                (clk_sys),
		.nrst                   (nrst),
		.internal_base_clock    (internal_base_clock),
		.internal_clock         (internal_clock),
		.external_clock         (external_clock),
		.external_reference     (external_reference),
		.internal_reference     (internal_reference),
		.filter_stable_signal   (filter_stable_signal),
		.filter_sample          (filter_sample),
		.internal_gen_on        (internal_gen_on),
		.external_gen_on        (external_gen_on),
		.crystal_select         (crystal_select),
		.run_in_stop            (run_in_stop),
		.stop_mode              (stop_mode),
		.bus_select_ext         (bus_select_ext),
		.freq_multiplier        (freq_multiplier),
		.osc_out_clock          (osc_out_clock),
		.gen_out_clock          (gen_out_clock),
		.bus_clock              (bus_clock),
		.timebase_clock         (timebase_clock),
		.internal_inactive_flag (internal_inactive_flag),
		.internal_stable_flag   (internal_stable_flag),
		.external_inactive_flag (external_inactive_flag),
		.external_stable_flag   (external_stable_flag),
		.active_multiplier      (active_multiplier),
		.crystal_range          (crystal_range)
	);

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// rises of osc, gen and bus over n cycles; a periodic clock gives an exact count
	task automatic rises(input int n);
		logic [2:0] was;
		r_osc = 0;
		r_gen = 0;
		r_bus = 0;
		was = {osc_out_clock, gen_out_clock, bus_clock};
		repeat (n) begin
			cyc(1);
			r_osc += int'(osc_out_clock && !was[2]);
			r_gen += int'(gen_out_clock && !was[1]);
			r_bus += int'(bus_clock && !was[0]);
			was = {osc_out_clock, gen_out_clock, bus_clock};
		end
	endtask
	// long low phase, short high: the rise closes the phase
	task automatic phase();
		{external_reference, internal_reference} = 2'b00;
		cyc(12);
		{external_reference, internal_reference} = 2'b11;
		cyc(2);
	endtask
	task automatic wait_ext(input int n);
		for (k = 0; k < n && external_stable_flag !== 1'b1; k++)
			cyc(1);
		if (k == n) begin
			n_mismatch++;
			stop_test();
		end
	endtask

	initial begin
		cyc(5);
		chk({osc_out_clock, gen_out_clock, bus_clock, timebase_clock, internal_inactive_flag,
			internal_stable_flag, external_inactive_flag, external_stable_flag}, 8'h00);
		nrst = 1'b1;
		foreach (rows[i]) begin
			{crystal_select, freq_multiplier} = rows[i][15:8];
			cyc(2);
			chk({crystal_range, active_multiplier}, rows[i][7:0]);
		end
		crystal_select = 1'b0;
		$display("table done");
		int_run = 1'b1;
		internal_gen_on = 1'b1;
		cyc(8);
		// source period 2: osc 2, gen 4, bus 8 cycles
		rises(80);
		chk(8'(r_osc), 8'h28);
		chk(8'(r_gen), 8'h14);
		chk(8'(r_bus), 8'h0A);
		$display("bus rate done");
		base_run = 1'b1;
		filter_stable_signal = 1'b1;
		for (int j = 0; j < 2; j++) begin
			filter_sample = 1'b1;
			cyc(1);
			filter_sample = 1'b0;
			cyc(3);
			chk(internal_stable_flag, 8'(j));
		end
		// first phase still holds the edge seen before the stop; two misses follow
		base_run = 1'b0;
		phase();
		phase();
		chk(internal_inactive_flag, 8'h00);
		phase();
		chk({internal_inactive_flag, internal_stable_flag}, 8'h02);
		{external_reference, internal_reference} = 2'b00;
		base_run = 1'b1;
		cyc(6);
		chk(internal_inactive_flag, 8'h00);
		$display("internal monitor done");
		ext_run = 1'b1;
		external_gen_on = 1'b1;
		cyc(40);
		chk(external_stable_flag, 8'h00);
		wait_ext(100);
		repeat (8) begin
			e = external_clock;
			cyc(1);
			chk(timebase_clock, e);
		end
		ext_run = 1'b0;
		phase();
		phase();
		chk(external_inactive_flag, 8'h00);
		phase();
		chk({external_inactive_flag, external_stable_flag}, 8'h02);
		{external_reference, internal_reference} = 2'b00;
		ext_run = 1'b1;
		cyc(8);
		chk(external_inactive_flag, 8'h00);
		wait_ext(100);
		external_gen_on = 1'b0;
		crystal_select = 1'b1;
		cyc(2);
		chk(external_stable_flag, 8'h00);
		external_gen_on = 1'b1;
		cyc(16000);
		chk(external_stable_flag, 8'h00);
		wait_ext(800);
		$display("external monitor done");
		stop_mode = 1'b1;
		cyc(3);
		repeat (6) begin
			cyc(1);
			chk({osc_out_clock, gen_out_clock, bus_clock, timebase_clock,
				external_stable_flag}, 8'h00);
		end
		$display("stop done");
		// external source kept alive in stop: period 4 gives osc 4, gen 8, bus 16
		run_in_stop = 1'b1;
		bus_select_ext = 1'b1;
		cyc(8);
		rises(80);
		chk(8'(r_osc), 8'h14);
		chk(8'(r_gen), 8'h0A);
		chk(8'(r_bus), 8'h05);
		$display("run in stop done");
		stop_test();
	end
endmodule
